// File: acfg_pkg.sv
package acfg_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int RST_PULSE_MIN_NS = 10;
   localparam int RST_PULSE_MAX_NS = 1000;
   // Longest pulse rounds down; a pin held longer than this is a strap tie
   localparam int STRAP_CYC = RST_PULSE_MAX_NS / CLK_PERIOD_NS;
   localparam int HWRST_MIN_CYC_RAW = (RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HWRST_MIN_CYC = (HWRST_MIN_CYC_RAW < 1) ? 1 : HWRST_MIN_CYC_RAW;
   localparam logic [5:0] STRAP_CYC_LAST = 6'(STRAP_CYC - 1);

   // ****************************************
   // Serial word and register file
   // ****************************************
   localparam logic [3:0] BIT_LAST = 4'h f;
   localparam logic [3:0] BIT_ADDR_LAST = 4'h7;
   localparam logic [3:0] BIT_RB_SHIFT_FIRST = 4'h9;
   localparam logic [7:0] REG_CTRL_ADDR = 8'h00;
   localparam int SWRST_BIT = 7;
   localparam int READOUT_BIT = 0;
   localparam logic [7:0] REG_RESET_VAL = 8'h00;

   // ****************************************
   // Select pin level codes
   // ****************************************
   localparam logic [1:0] LVL_GND = 2'h0;
   localparam logic [1:0] LVL_LOW_MID = 2'h1;
   localparam logic [1:0] LVL_HIGH_MID = 2'h2;
   localparam logic [1:0] LVL_SUPPLY = 2'h3;

   // ****************************************
   // APB map
   // ****************************************
   localparam logic [7:0] APB_STATUS = 8'h00;
   localparam logic [7:0] APB_PEEK_ADDR = 8'h04;
   localparam logic [7:0] APB_PEEK_DATA = 8'h08;
   localparam logic [7:0] APB_WORDS = 8'h0C;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_READOUT = 2;
   localparam int ST_CFG_LSB = 3;
   localparam int ST_RB_OE = 11;

   typedef enum logic [1:0] {CM_SERIAL, CM_HWRST, CM_STRAP} acfg_mode_t;

   typedef struct packed {
      logic sel_n;
      logic serial_data_in;
      logic sclk;
      logic rst_pin;
      logic strap1;
      logic strap2;
      logic strap3;
      logic sclk_thr;
      logic [1:0] sel_lvl;
   } acfg_pins_t;

   typedef struct packed {
      logic low_speed;
      logic twos_comp;
      logic lvds_if;
      logic ns_en_a;
      logic ns_en_b;
      logic pdn_global;
      logic pdn_a;
      logic mux_b;
   } acfg_cfg_t;

   typedef struct packed {
      acfg_pins_t s1;
      acfg_pins_t s2;
      logic sclk_d;
      acfg_mode_t mode;
      logic [5:0] hi_cnt;
      logic [3:0] bit_cnt;
      logic [15:0] shreg;
      logic [7:0] rb_shift;
      logic rb_out;
      logic rb_oe;
      logic [255:0][7:0] regs;
      logic [15:0] words;
      logic [7:0] peek;
      acfg_cfg_t cfg;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } acfg_state_t;

endpackage

// File: acfg_top.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - Reset pin tied high selects strap-only setup; no reset pulse needed.
// - Strap mode: shift-clock level above threshold enables low-speed mode.
// - Strap mode: four select levels choose output format and interface.
// - First strap low: other two straps enable noise shaping per channel.
// - First strap high: low/low global power-down, low/high channel A down.
// - All three straps high: both channels multiplexed onto channel B bus.
// - Reset pin low after register reset: pins form the serial port.
// - Combined mode: straps still apply while serial accesses are accepted.
// - Shift data in only while select is low, on falling shift clock.
// - Every sixteenth falling edge commits a word; leftover bits dropped.
// - Word is eight address bits then eight data bits.
// - Serial port works from maximum rate down to hertz, any duty.
// - Registers default after power-up; reset pin high pulse restores defaults.
// - Writing software reset bit clears all registers, bit self-clears.
// - While readback enable is set, writes to every register but the control register are blocked.
// - Readback: after address, register data driven on readback pin.
// - Clearing readback enable makes registers writable again.
// - Readback disabled keeps readback pin undriven.
// - Hardware or software reset returns every register to zero.
module acfg_top
   import acfg_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic RESET_PIN_I,
   input wire logic SERIAL_SELECT_LOW_I,
   input wire logic SERIAL_DATA_IN_I,
   input wire logic SHIFT_CLK_I,
   input wire logic [1:0] SELECT_LEVEL_I,
   input wire logic SHIFT_CLK_ABOVE_THR_I,
   input wire logic MODE_STRAP_FIRST_I,
   input wire logic MODE_STRAP_SECOND_I,
   input wire logic MODE_STRAP_THIRD_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic SERIAL_READBACK_OUT_O,
   output logic SERIAL_READBACK_OE_O,
   output logic LOW_SPEED_O,
   output logic TWOS_COMP_O,
   output logic LVDS_IF_O,
   output logic NS_EN_A_O,
   output logic NS_EN_B_O,
   output logic PDN_GLOBAL_O,
   output logic PDN_A_O,
   output logic MUX_B_O,
   output logic [1:0] CFG_MODE_O
);

   // ****************************************
   // Decoders
   // ****************************************
   function automatic acfg_cfg_t strap_dec(input logic c1, input logic c2, input logic c3);
      acfg_cfg_t r;
      r = '0;
      if (!c1) begin
         r.ns_en_a = c2;
         r.ns_en_b = c3;
      end else begin
         // High/low is a forbidden tie; nothing is enabled for it
         r.pdn_global = !c2 && !c3;
         r.pdn_a = !c2 && c3;
         r.mux_b = c2 && c3;
      end
      return r;
   endfunction

   function automatic logic [1:0] sel_dec(input logic [1:0] lvl);
      logic [1:0] r;
      r = 2'h0;
      case (lvl)
         LVL_GND: r = 2'h2;
         LVL_LOW_MID: r = 2'h0;
         LVL_HIGH_MID: r = 2'h1;
         LVL_SUPPLY: r = 2'h3;
         default: r = 2'h0;
      endcase
      return r;
   endfunction

   acfg_state_t st;
   acfg_state_t nxt_st;
   acfg_pins_t pins_in;
   logic sclk_fall;
   logic sclk_rise;
   logic ser_active;
   logic readout;
   logic [15:0] word_in;
   logic wr_ok;
   logic [7:0] rb_pick;
   logic [1:0] fmt;
   logic apb_setup;
   logic apb_write;

   assign pins_in = '{sel_n: SERIAL_SELECT_LOW_I, serial_data_in: SERIAL_DATA_IN_I, sclk: SHIFT_CLK_I,
                      rst_pin: RESET_PIN_I, strap1: MODE_STRAP_FIRST_I,
                      strap2: MODE_STRAP_SECOND_I, strap3: MODE_STRAP_THIRD_I,
                      sclk_thr: SHIFT_CLK_ABOVE_THR_I, sel_lvl: SELECT_LEVEL_I};
   // Edges found on the core clock make any slow rate or duty cycle work
   assign sclk_fall = st.sclk_d && !st.s2.sclk;
   assign sclk_rise = !st.sclk_d && st.s2.sclk;
   assign ser_active = (st.mode == CM_SERIAL) && !st.s2.rst_pin && !st.s2.sel_n;
   assign readout = st.regs[REG_CTRL_ADDR][READOUT_BIT];
   assign word_in = {st.shreg[14:0], st.s2.serial_data_in};
   // Control register stays writable so readback can be switched off
   assign wr_ok = !readout || (word_in[15:8] == REG_CTRL_ADDR);
   assign rb_pick = st.regs[word_in[7:0]];
   assign fmt = sel_dec(st.s2.sel_lvl);
   assign apb_setup = PSEL_I && !PENABLE_I && !st.pready;
   assign apb_write = PSEL_I && PENABLE_I && st.pready && PWRITE_I;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      nxt_st = st;
      nxt_st.s1 = pins_in;
      nxt_st.s2 = st.s1;
      nxt_st.sclk_d = st.s2.sclk;

      case (st.mode)
         CM_SERIAL: begin
            if (st.s2.rst_pin) begin
               nxt_st.mode = CM_HWRST;
               nxt_st.hi_cnt = 6'h01;
            end
         end
         CM_HWRST: begin
            if (!st.s2.rst_pin) begin
               nxt_st.mode = CM_SERIAL;
            end else if (st.hi_cnt == STRAP_CYC_LAST) begin
               nxt_st.mode = CM_STRAP;
            end else begin
               nxt_st.hi_cnt = st.hi_cnt + 6'h01;
            end
         end
         CM_STRAP: begin
            if (!st.s2.rst_pin) begin
               nxt_st.mode = CM_SERIAL;
            end
         end
         default: nxt_st.mode = CM_SERIAL;
      endcase

      // Serial engine
      if (!ser_active) begin
         nxt_st.bit_cnt = 4'h0;
      end else if (sclk_fall) begin
         nxt_st.shreg = word_in;
         nxt_st.bit_cnt = st.bit_cnt + 4'h1;
         if (st.bit_cnt == BIT_ADDR_LAST && readout) begin
            nxt_st.rb_shift = rb_pick;
            nxt_st.rb_out = rb_pick[7];
         end
         if (st.bit_cnt == BIT_LAST) begin
            nxt_st.words = st.words + 16'h0001;
            if (wr_ok) begin
               if (word_in[15:8] == REG_CTRL_ADDR && word_in[7 - 0 - 0 + SWRST_BIT - 7 + 0]) begin
                  nxt_st.regs = '0;
               end else begin
                  nxt_st.regs[word_in[15:8]] = word_in[7:0];
               end
            end
         end
      end else if (sclk_rise && st.bit_cnt >= BIT_RB_SHIFT_FIRST) begin
         nxt_st.rb_shift = {st.rb_shift[6:0], 1'b0};
         nxt_st.rb_out = st.rb_shift[6];
      end

      // Reset pin high clears the file; held high it stays cleared
      if (st.s2.rst_pin || st.mode != CM_SERIAL) begin
         nxt_st.regs = '0;
      end
      nxt_st.rb_oe = readout && st.mode == CM_SERIAL;
      if (!readout) begin
         nxt_st.rb_out = 1'b0;
      end

      nxt_st.cfg = strap_dec(st.s2.strap1, st.s2.strap2, st.s2.strap3);
      if (st.mode == CM_STRAP) begin
         nxt_st.cfg.low_speed = st.s2.sclk_thr;
         nxt_st.cfg.twos_comp = fmt[1];
         nxt_st.cfg.lvds_if = fmt[0];
      end

      // APB slave, one wait-free access phase
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
      if (apb_setup) begin
         nxt_st.pready = 1'b1;
         nxt_st.prdata = 32'h0000_0000;
         case (PADDR_I)
            APB_STATUS: begin
               nxt_st.prdata[ST_MODE_LSB +: 2] = st.mode;
               nxt_st.prdata[ST_READOUT] = readout;
               nxt_st.prdata[ST_CFG_LSB +: 8] = st.cfg;
               nxt_st.prdata[ST_RB_OE] = st.rb_oe;
            end
            APB_PEEK_ADDR: nxt_st.prdata[7:0] = st.peek;
            APB_PEEK_DATA: nxt_st.prdata[7:0] = st.regs[st.peek];
            APB_WORDS: nxt_st.prdata[15:0] = st.words;
            default: nxt_st.pslverr = 1'b1;
         endcase
      end
      if (apb_write && PADDR_I == APB_PEEK_ADDR) begin
         nxt_st.peek = PWDATA_I[7:0];
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         st <= '0;
      end else begin
         st <= nxt_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign PRDATA_O = st.prdata;
   assign PREADY_O = st.pready;
   assign PSLVERR_O = st.pslverr;
   assign SERIAL_READBACK_OUT_O = st.rb_out;
   assign SERIAL_READBACK_OE_O = st.rb_oe;
   assign LOW_SPEED_O = st.cfg.low_speed;
   assign TWOS_COMP_O = st.cfg.twos_comp;
   assign LVDS_IF_O = st.cfg.lvds_if;
   assign NS_EN_A_O = st.cfg.ns_en_a;
   assign NS_EN_B_O = st.cfg.ns_en_b;
   assign PDN_GLOBAL_O = st.cfg.pdn_global;
   assign PDN_A_O = st.cfg.pdn_a;
   assign MUX_B_O = st.cfg.mux_b;
   assign CFG_MODE_O = st.mode;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);

   sequence s_last_fall;
      ser_active && sclk_fall && st.bit_cnt == BIT_LAST;
   endsequence

   sequence s_addr_done;
      ser_active && sclk_fall && st.bit_cnt == BIT_ADDR_LAST && readout;
   endsequence

   chk_strap_entry: assert property ((st.mode == CM_HWRST && st.s2.rst_pin &&
      st.hi_cnt == STRAP_CYC_LAST) |=> st.mode == CM_STRAP)
      else $error("strap mode not entered");
   chk_low_speed: assert property (st.mode == CM_STRAP |=>
      st.cfg.low_speed == $past(st.s2.sclk_thr))
      else $error("low-speed strap wrong");
   chk_fmt_lowmid: assert property ((st.mode == CM_STRAP && st.s2.sel_lvl == LVL_LOW_MID) |=>
      (!st.cfg.twos_comp && !st.cfg.lvds_if))
      else $error("format decode wrong");
   chk_ns_both: assert property ((!st.s2.strap1 && st.s2.strap2 && st.s2.strap3) |=>
      (st.cfg.ns_en_a && st.cfg.ns_en_b && !st.cfg.mux_b))
      else $error("noise shaping decode wrong");
   chk_pdn_chan_a: assert property ((st.s2.strap1 && !st.s2.strap2 && st.s2.strap3) |=>
      (st.cfg.pdn_a && !st.cfg.pdn_global))
      else $error("channel A power-down wrong");
   chk_mux_all: assert property ((st.s2.strap1 && st.s2.strap2 && st.s2.strap3) |=>
      st.cfg.mux_b)
      else $error("mux mode wrong");
   chk_word_count: assert property (s_last_fall |=>
      (st.words == $past(st.words) + 16'h0001 && st.bit_cnt == 4'h0))
      else $error("word not committed");
   chk_select_abort: assert property (st.s2.sel_n |=> st.bit_cnt == 4'h0)
      else $error("bits kept outside select");
   chk_write_block: assert property ((s_last_fall ##0 (readout &&
      word_in[15:8] != REG_CTRL_ADDR && !st.s2.rst_pin)) |=> $stable(st.regs))
      else $error("write not blocked");
   chk_swrst_clear: assert property ((s_last_fall ##0 (word_in[15:8] == REG_CTRL_ADDR &&
      word_in[SWRST_BIT])) |=> st.regs[REG_CTRL_ADDR] == REG_RESET_VAL)
      else $error("software reset not cleared");
   chk_hw_clear: assert property (st.s2.rst_pin |=> st.regs == '0)
      else $error("reset pin did not clear");
   chk_rb_msb: assert property (s_addr_done |=> st.rb_out == $past(rb_pick[7]))
      else $error("readback msb wrong");
   chk_rb_hiz: assert property (!readout |=> !st.rb_oe)
      else $error("readback pin driven");

endmodule

// File: acfg_ctrl_model.sv
`timescale 1ns/1ps
module acfg_ctrl_model
   import acfg_pkg::*;
(
   input wire logic rb_i,
   input wire logic rb_oe_i,
   output logic sel_n_o,
   output logic serial_data_in_o,
   output logic sclk_o
);
   // ****************************************
   // Uneven duty cycle, 160 ns period
   // ****************************************
   // Long high phase: readback shifts on the rise and needs time before the next fall
   localparam int T_HI = 100;
   localparam int T_LO = 60;

   initial begin
      sel_n_o = 1'b1;
      serial_data_in_o = 1'b0;
      sclk_o = 1'b1;
   end

   // Clock stands high between frames; data flips once released
   task automatic frame(input logic [47:0] bits, input int n, output logic [7:0] rb);
      rb = 8'h00;
      // Off the core clock edge, so the synchronisers never race a pin change
      #5;
      sel_n_o = 1'b0;
      #40;
      for (int i = 0; i < n; i++) begin
         serial_data_in_o = bits[47 - i];
         #T_HI;
         sclk_o = 1'b0;
         if (i >= 8 && i < 16) begin
            rb = {rb[6:0], rb_oe_i ? rb_i : 1'bx};
         end
         #T_LO;
         sclk_o = 1'b1;
      end
      #40;
      sel_n_o = 1'b1;
      serial_data_in_o = ~serial_data_in_o;
      #40;
   endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench
   import acfg_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rst_pin = 1'b0;
   logic [2:0] straps = 3'h0;
   logic [1:0] sel_lvl = 2'h0;
   logic thr = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] PRDATA_O;
   logic PREADY_O, PSLVERR_O, rb_out, rb_oe, sel_n, serial_data_in, sclk;
   logic LOW_SPEED_O, TWOS_COMP_O, LVDS_IF_O, NS_EN_A_O, NS_EN_B_O;
   logic PDN_GLOBAL_O, PDN_A_O, MUX_B_O;
   logic [1:0] CFG_MODE_O;
   int fail_count = 0;
   int compares = 0;
   logic [31:0] v;
   logic [7:0] rb;
   logic e;

   always #10 clk = ~clk;

   acfg_top dut (.CORE_CLK_I(clk), .RST_I(rst), .RESET_PIN_I(rst_pin),
      .SERIAL_SELECT_LOW_I(sel_n), .SERIAL_DATA_IN_I(serial_data_in), .SHIFT_CLK_I(sclk),
      .SELECT_LEVEL_I(sel_lvl), .SHIFT_CLK_ABOVE_THR_I(thr),
      .MODE_STRAP_FIRST_I(straps[2]), .MODE_STRAP_SECOND_I(straps[1]),
      .MODE_STRAP_THIRD_I(straps[0]), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(PRDATA_O),
      .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SERIAL_READBACK_OUT_O(rb_out),
      .SERIAL_READBACK_OE_O(rb_oe), .LOW_SPEED_O(LOW_SPEED_O), .TWOS_COMP_O(TWOS_COMP_O),
      .LVDS_IF_O(LVDS_IF_O), .NS_EN_A_O(NS_EN_A_O), .NS_EN_B_O(NS_EN_B_O),
      .PDN_GLOBAL_O(PDN_GLOBAL_O), .PDN_A_O(PDN_A_O), .MUX_B_O(MUX_B_O),
      .CFG_MODE_O(CFG_MODE_O));

   acfg_ctrl_model ctrl (.rb_i(rb_out), .rb_oe_i(rb_oe), .sel_n_o(sel_n),
      .serial_data_in_o(serial_data_in), .sclk_o(sclk));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (PREADY_O !== 1'b1 && n < 20);
      if (n >= 20) fail_count++;
      rd = PRDATA_O;
      err = PSLVERR_O;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic peek(input logic [7:0] a, output logic [31:0] d);
      logic er;
      apb(1'b1, APB_PEEK_ADDR, {24'h00_0000, a}, d, er);
      apb(1'b0, APB_PEEK_DATA, 32'h0000_0000, d, er);
   endtask

   // Pin synchronisers need a few core cycles after the last edge
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      ctrl.frame({a, d, 32'h0000_0000}, 16, r);
      repeat (8) @(posedge clk);
   endtask

   initial begin
      #400_000;
      fail_count++;
      stop_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
      apb(1'b0, APB_STATUS, 32'h0000_0000, v, e);
      check(v, 32'h0000_0000);
      check({31'h0, rb_oe}, 32'h0000_0000);
      sw(8'h45, 8'h04);
      peek(8'h45, v);
      check(v, 32'h0000_0004);
      ctrl.frame({16'h10A5, 16'h113C, 16'h12FF}, 39, rb);
      repeat (8) @(posedge clk);
      peek(8'h10, v);
      check(v, 32'h0000_00A5);
      peek(8'h11, v);
      check(v, 32'h0000_003C);
      peek(8'h12, v);
      check(v, 32'h0000_0000);
      apb(1'b0, APB_WORDS, 32'h0000_0000, v, e);
      check(v, 32'h0000_0003);
      sw(8'h00, 8'h01);
      apb(1'b0, APB_STATUS, 32'h0000_0000, v, e);
      check(32'({v[ST_RB_OE], v[ST_READOUT], rb_oe}), 32'h0000_0007);
      ctrl.frame({16'h4500, 32'h0000_0000}, 16, rb);
      check(32'(rb), 32'h0000_0004);
      ctrl.frame({16'h1000, 32'h0000_0000}, 16, rb);
      check(32'(rb), 32'h0000_00A5);
      sw(8'h45, 8'h77);
      peek(8'h45, v);
      check(v, 32'h0000_0004);
      sw(8'h00, 8'h00);
      sw(8'h45, 8'h77);
      peek(8'h45, v);
      check(v, 32'h0000_0077);
      check({31'h0, rb_oe}, 32'h0000_0000);
      sw(8'h00, 8'h80);
      peek(8'h45, v);
      check(v, 32'h0000_0000);
      peek(8'h00, v);
      check(v, 32'h0000_0000);
      sw(8'h10, 8'h5A);
      rst_pin <= 1'b1;
      repeat (2) @(posedge clk);
      rst_pin <= 1'b0;
      repeat (10) @(posedge clk);
      peek(8'h10, v);
      check(v, 32'h0000_0000);
      // Comparator inputs high: format outputs must still read zero here
      thr <= 1'b1;
      sel_lvl <= LVL_SUPPLY;
      for (int i = 0; i < 8; i++) begin
         if (i != 6) begin
            straps <= 3'(i);
            repeat (6) @(posedge clk);
            check(32'({NS_EN_A_O, NS_EN_B_O, PDN_GLOBAL_O, PDN_A_O, MUX_B_O, LOW_SPEED_O,
               TWOS_COMP_O, LVDS_IF_O}), 32'({!i[2] && i[1], !i[2] && i[0],
               i[2:0] == 3'h4, i[2:0] == 3'h5, i[2:0] == 3'h7, 3'h0}));
         end
      end
      straps <= 3'h0;
      rst_pin <= 1'b1;
      repeat (60) @(posedge clk);
      check(32'(CFG_MODE_O), 32'h0000_0002);
      for (int j = 0; j < 8; j++) begin
         sel_lvl <= 2'(j);
         thr <= j[2];
         repeat (6) @(posedge clk);
         check(32'({LOW_SPEED_O, TWOS_COMP_O, LVDS_IF_O}),
            32'({j[2], j[1] == j[0], j[1]}));
      end
      apb(1'b0, 8'h10, 32'h0000_0000, v, e);
      check({31'h0, e}, 32'h0000_0001);
      check(v, 32'h0000_0000);
      rst_pin <= 1'b0;
      repeat (4) @(posedge clk);
      check(32'(CFG_MODE_O), 32'h0000_0000);
      stop_test();
   end
endmodule
